// [verilog/sstu_pkg.sv]
// Constants and types shared by the subtract, swap and test-and-set unit.
// How it works
// - Plain subtract writes destination minus source to the destination in one cycle and leaves the flag alone.
// - Subtract-with-borrow writes destination minus source minus the flag in one cycle.
// - Subtract-with-borrow sets the flag on a borrow from either step and clears it otherwise.
// - Checked subtract writes the two's complement difference to the destination in one cycle.
// - Checked subtract sets the flag only when operand signs differ and the result sign leaves the destination sign.
// - Byte swap exchanges the two low bytes of the source, keeps its upper half, and writes the destination.
// - Halfword swap exchanges the two halves of the source and writes the destination.
// - Test-and-set reads the byte at the destination address, sets the flag when it is zero, and takes 4 cycles.
// - Test-and-set then forces bit 7 of that byte and writes it back to the same address.
// - The bus stays locked from the test-and-set read until its write completes.
package sstu_pkg;
  // ****************************************
  // Opcode patterns
  // ****************************************
  localparam logic [15:0] SSTU_OP_SUB = 16'h3008;
  localparam logic [15:0] SSTU_OP_SUBB = 16'h300A;
  localparam logic [15:0] SSTU_OP_CHECKED_SUBTRACT_OP = 16'h300B;
  localparam logic [15:0] SSTU_OP_SWPB = 16'h6008;
  localparam logic [15:0] SSTU_OP_SWPW = 16'h6009;
  localparam logic [15:0] SSTU_OP_TAS = 16'h401B;
  localparam logic [15:0] SSTU_MASK_RR = 16'hF00F;
  localparam logic [15:0] SSTU_MASK_TAS = 16'hF0FF;
  // ****************************************
  // Fields and timing
  // ****************************************
  localparam int SSTU_DST_LSB = 8;
  localparam int SSTU_SRC_LSB = 4;
  localparam int SSTU_IDX_W = 4;
  localparam int SSTU_SET_BIT = 7;
  localparam int SSTU_TAS_CYCLES = 4;
  localparam logic [31:0] SSTU_ZERO_WORD = 32'h0000_0000;
  localparam logic [7:0] SSTU_ZERO_BYTE = 8'h00;
  typedef enum logic [2:0] {
    SSTU_ALU_SUB = 3'b000,
    SSTU_ALU_SUBB = 3'b001,
    SSTU_ALU_CHECKED_SUBTRACT_OP = 3'b010,
    SSTU_ALU_SWPB = 3'b011,
    SSTU_ALU_SWPW = 3'b100
  } sstu_alu_op_t;
  typedef enum logic [2:0] {
    SSTU_ST_IDLE = 3'b000,
    SSTU_ST_READ = 3'b001,
    SSTU_ST_MOD = 3'b010,
    SSTU_ST_WRITE = 3'b011,
    SSTU_ST_DONE = 3'b100
  } sstu_tas_state_t;
endpackage

// [verilog/sstu_alu.sv]
// Combinational subtract and swap datapath.
`timescale 1ns/1ps
`default_nettype none
module sstu_alu (
  input wire sstu_pkg::sstu_alu_op_t op,
  input wire logic [31:0] dest_val,
  input wire logic [31:0] src_val,
  input wire logic flag_in,
  output logic [31:0] result,
  output logic flag_out
);
  import sstu_pkg::*;
  wire [32:0] diff_ext = {1'b0, dest_val} - {1'b0, src_val};
  wire [31:0] diff = diff_ext[31:0];
  wire borrow1 = diff_ext[32];
  wire [32:0] subb_ext = {1'b0, diff} - {32'h0000_0000, flag_in};
  wire borrow2 = subb_ext[32];
  wire sign_diff = dest_val[31] ^ src_val[31];
  wire ovf = sign_diff && (diff[31] != dest_val[31]);
  wire [31:0] swap_b = {src_val[31:16], src_val[7:0], src_val[15:8]};
  wire [31:0] swap_w = {src_val[15:0], src_val[31:16]};
  always_comb begin
    result = diff;
    flag_out = flag_in;
    case (op)
      SSTU_ALU_SUB: result = diff;
      SSTU_ALU_SUBB: begin
        result = subb_ext[31:0];
        flag_out = borrow1 | borrow2;
      end
      SSTU_ALU_CHECKED_SUBTRACT_OP: begin
        result = diff;
        flag_out = ovf;
      end
      SSTU_ALU_SWPB: result = swap_b;
      SSTU_ALU_SWPW: result = swap_w;
      default: result = diff;
    endcase
  end
endmodule
`default_nettype wire

// [verilog/sstu_tas.sv]
// Atomic test-and-set sequencer on the memory bus.
`timescale 1ns/1ps
`default_nettype none
module sstu_tas (
  input wire logic clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic [31:0] addr,
  input wire logic [7:0] rd_byte,
  output logic [31:0] bus_addr_q,
  output logic bus_rd_q,
  output logic bus_wr_q,
  output logic bus_lock_q,
  output logic [7:0] bus_wdata_q,
  output logic flag_valid_q,
  output logic flag_q,
  output logic busy
);
  import sstu_pkg::*;
  sstu_tas_state_t state_q, state_d;
  // A fixed walk keeps the instruction at exactly four cycles.
  // The byte arrives in the cycle after the read strobe leaves the unit.
  always_comb begin
    state_d = state_q;
    case (state_q)
      SSTU_ST_IDLE: if (start) state_d = SSTU_ST_READ;
      SSTU_ST_READ: state_d = SSTU_ST_MOD;
      SSTU_ST_MOD: state_d = SSTU_ST_WRITE;
      SSTU_ST_WRITE: state_d = SSTU_ST_DONE;
      SSTU_ST_DONE: begin
        state_d = SSTU_ST_IDLE;
        if (start) state_d = SSTU_ST_READ;
      end
      default: state_d = SSTU_ST_IDLE;
    endcase
  end
  // The last state only hands the flag over, so a new instruction may start there.
  assign busy = (state_q != SSTU_ST_IDLE) && (state_q != SSTU_ST_DONE);
  wire lock_d = (state_d == SSTU_ST_READ) || (state_d == SSTU_ST_MOD) ||
                (state_d == SSTU_ST_WRITE);
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= SSTU_ST_IDLE;
      bus_addr_q <= SSTU_ZERO_WORD;
      bus_rd_q <= 1'b0;
      bus_wr_q <= 1'b0;
      bus_lock_q <= 1'b0;
      bus_wdata_q <= SSTU_ZERO_BYTE;
      flag_valid_q <= 1'b0;
      flag_q <= 1'b0;
    end else begin
      state_q <= state_d;
      bus_lock_q <= lock_d;
      bus_rd_q <= (state_d == SSTU_ST_READ);
      bus_wr_q <= (state_d == SSTU_ST_WRITE);
      flag_valid_q <= (state_d == SSTU_ST_DONE);
      if (start) begin
        bus_addr_q <= addr;
      end
      if (state_q == SSTU_ST_WRITE) begin
        flag_q <= (rd_byte == SSTU_ZERO_BYTE);
        bus_wdata_q <= rd_byte | (8'h01 << SSTU_SET_BIT);
      end
    end
  end
endmodule
`default_nettype wire

// [verilog/sstu_unit.sv]
// Top of the subtract, swap and test-and-set execution unit.
`timescale 1ns/1ps
`default_nettype none
module sstu_unit (
  input wire logic clk,
  input wire logic resetn,
  input wire logic instr_valid,
  input wire logic [15:0] instr,
  input wire logic [31:0] dest_register,
  input wire logic [31:0] source_register,
  input wire logic flag_in,
  input wire logic [7:0] mem_rdata,
  output logic [3:0] dest_idx_q,
  output logic [3:0] src_idx_q,
  output logic [31:0] wb_data_q,
  output logic wb_en_q,
  output logic flag_q,
  output logic flag_wr_q,
  output logic busy_q,
  output logic illegal_q,
  output logic [31:0] mem_addr_q,
  output logic mem_rd_q,
  output logic mem_wr_q,
  output logic mem_lock_q,
  output logic [7:0] mem_wdata_q
);
  import sstu_pkg::*;
  // ****************************************
  // Decode
  // ****************************************
  wire [3:0] dst_idx = instr[SSTU_DST_LSB +: SSTU_IDX_W];
  wire [3:0] src_idx = instr[SSTU_SRC_LSB +: SSTU_IDX_W];
  wire [15:0] rr_key = instr & SSTU_MASK_RR;
  wire [15:0] tas_key = instr & SSTU_MASK_TAS;
  wire tas_busy;
  wire is_sub = (rr_key == SSTU_OP_SUB);
  wire is_subb = (rr_key == SSTU_OP_SUBB);
  wire is_checked_subtract_op = (rr_key == SSTU_OP_CHECKED_SUBTRACT_OP);
  wire is_swpb = (rr_key == SSTU_OP_SWPB);
  wire is_swpw = (rr_key == SSTU_OP_SWPW);
  wire is_tas = (tas_key == SSTU_OP_TAS);
  wire is_rr = is_sub | is_subb | is_checked_subtract_op | is_swpb | is_swpw;
  // Instructions offered while a test-and-set runs are not taken; the core must hold them.
  wire accept = instr_valid && !tas_busy;
  sstu_alu_op_t alu_op;
  assign alu_op = is_subb ? SSTU_ALU_SUBB :
                  is_checked_subtract_op ? SSTU_ALU_CHECKED_SUBTRACT_OP :
                  is_swpb ? SSTU_ALU_SWPB :
                  is_swpw ? SSTU_ALU_SWPW : SSTU_ALU_SUB;
  wire [31:0] alu_res;
  wire alu_flag;
  sstu_alu u_alu (
    .op(alu_op),
    .dest_val(dest_register),
    .src_val(source_register),
    .flag_in(flag_in),
    .result(alu_res),
    .flag_out(alu_flag)
  );
  wire [31:0] t_addr;
  wire t_rd;
  wire t_wr;
  wire t_lock;
  wire [7:0] t_wdata;
  wire t_fvalid;
  wire t_flag;
  sstu_tas u_tas (
    .clk(clk),
    .resetn(resetn),
    .start(accept && is_tas),
    .addr(dest_register),
    .rd_byte(mem_rdata),
    .bus_addr_q(t_addr),
    .bus_rd_q(t_rd),
    .bus_wr_q(t_wr),
    .bus_lock_q(t_lock),
    .bus_wdata_q(t_wdata),
    .flag_valid_q(t_fvalid),
    .flag_q(t_flag),
    .busy(tas_busy)
  );
  // ****************************************
  // Registered outputs
  // ****************************************
  // The write strobe leaves as the byte arrives, so the set byte is taken off the bus here.
  wire [7:0] tas_wbyte = mem_rdata | (8'h01 << SSTU_SET_BIT);
  wire rr_go = accept && is_rr;
  wire flag_upd = rr_go && (is_subb || is_checked_subtract_op);
  always_ff @(posedge clk) begin
    if (!resetn) begin
      dest_idx_q <= 4'h0;
      src_idx_q <= 4'h0;
      wb_data_q <= SSTU_ZERO_WORD;
      wb_en_q <= 1'b0;
      flag_q <= 1'b0;
      flag_wr_q <= 1'b0;
      busy_q <= 1'b0;
      illegal_q <= 1'b0;
      mem_addr_q <= SSTU_ZERO_WORD;
      mem_rd_q <= 1'b0;
      mem_wr_q <= 1'b0;
      mem_lock_q <= 1'b0;
      mem_wdata_q <= SSTU_ZERO_BYTE;
    end else begin
      if (accept) begin
        dest_idx_q <= dst_idx;
        src_idx_q <= src_idx;
      end
      wb_en_q <= rr_go;
      if (rr_go) begin
        wb_data_q <= alu_res;
      end
      flag_wr_q <= flag_upd | t_fvalid;
      if (flag_upd) begin
        flag_q <= alu_flag;
      end else if (t_fvalid) begin
        flag_q <= t_flag;
      end
      busy_q <= tas_busy || (accept && is_tas);
      illegal_q <= accept && !is_rr && !is_tas;
      mem_addr_q <= t_addr;
      mem_rd_q <= t_rd;
      mem_wr_q <= t_wr;
      mem_lock_q <= t_lock;
      mem_wdata_q <= t_wr ? tas_wbyte : t_wdata;
    end
  end
endmodule
`default_nettype wire

// [bench/sstu_unit_asserts.sv]
// Port assertions for the subtract, swap and test-and-set unit.
`timescale 1ns/1ps
`default_nettype none
module sstu_unit_chk
  import sstu_pkg::*;
(
  input wire logic clk, resetn, instr_valid, flag_in, busy_q, wb_en_q, flag_q, flag_wr_q,
  input wire logic mem_rd_q, mem_wr_q, mem_lock_q,
  input wire logic [15:0] instr,
  input wire logic [31:0] dest_register, source_register, wb_data_q, mem_addr_q,
  input wire logic illegal_q,
  input wire logic [3:0] dest_idx_q, src_idx_q,
  input wire logic [7:0] mem_rdata, mem_wdata_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire logic [15:0] rr = instr & SSTU_MASK_RR;
  // Internal busy ends one cycle before busy_q; the write strobe marks that cycle.
  wire logic go = instr_valid && (!busy_q || mem_wr_q);
  wire logic [31:0] d = dest_register;
  wire logic [31:0] s = source_register;
  wire logic [31:0] dms = d - s;
  wire logic [32:0] bw = {1'b0, d} - {1'b0, s} - {32'h0000_0000, flag_in};
  wire logic [31:0] bwr = bw[31:0];
  wire logic bwc = bw[32];
  wire logic vf = (d[31] != s[31]) && (dms[31] != d[31]);
  wire logic [31:0] swb = {s[31:16], s[7:0], s[15:8]};
  wire logic [31:0] sww = {s[15:0], s[31:16]};
  wire logic [3:0] didx = instr[11:8];
  wire logic [3:0] sidx = instr[7:4];
  wire logic in_grp = rr == SSTU_OP_SUB || rr == SSTU_OP_SUBB || rr == SSTU_OP_CHECKED_SUBTRACT_OP ||
    rr == SSTU_OP_SWPB || rr == SSTU_OP_SWPW || (instr & SSTU_MASK_TAS) == SSTU_OP_TAS;
  property p_sub; go && rr == SSTU_OP_SUB |=>
    wb_en_q && !flag_wr_q && wb_data_q == $past(dms); endproperty
  a_sub: assert property (p_sub) else $error("subtract result wrong");
  property p_subb; go && rr == SSTU_OP_SUBB |=>
    wb_en_q && wb_data_q == $past(bwr) && flag_wr_q && flag_q == $past(bwc); endproperty
  a_subb: assert property (p_subb) else $error("borrow subtract wrong");
  property p_checked_subtract_op; go && rr == SSTU_OP_CHECKED_SUBTRACT_OP |=>
    wb_en_q && wb_data_q == $past(dms) && flag_wr_q && flag_q == $past(vf); endproperty
  a_checked_subtract_op: assert property (p_checked_subtract_op) else $error("checked subtract wrong");
  property p_swpb; go && rr == SSTU_OP_SWPB |=> wb_en_q && wb_data_q == $past(swb); endproperty
  a_swpb: assert property (p_swpb) else $error("byte swap wrong");
  property p_swpw; go && rr == SSTU_OP_SWPW |=> wb_en_q && wb_data_q == $past(sww); endproperty
  a_swpw: assert property (p_swpw) else $error("halfword swap wrong");
  property p_idx; wb_en_q |-> dest_idx_q == $past(didx); endproperty
  a_idx: assert property (p_idx) else $error("destination index wrong");
  property p_tas; go && (instr & SSTU_MASK_TAS) == SSTU_OP_TAS |-> ##2 mem_rd_q &&
    mem_addr_q == $past(d, 2) ##2 mem_wr_q ##1 flag_wr_q &&
    flag_q == ($past(mem_rdata, 2) == 8'h00) && !mem_lock_q; endproperty
  a_tas: assert property (p_tas) else $error("test-and-set sequence wrong");
  property p_wr; mem_rd_q |-> ##2 mem_wr_q && mem_wdata_q == ($past(mem_rdata) | 8'h80);
  endproperty
  a_wr: assert property (p_wr) else $error("write-back byte wrong");
  property p_lock; mem_rd_q |-> mem_lock_q [*3]; endproperty
  a_lock: assert property (p_lock) else $error("bus lock dropped");
  property p_sidx; wb_en_q |-> src_idx_q == $past(sidx); endproperty
  a_sidx: assert property (p_sidx) else $error("source index wrong");
  property p_ill; go |=> (illegal_q == !$past(in_grp)); endproperty
  a_ill: assert property (p_ill) else $error("opcode decode wrong");
endmodule
bind sstu_unit sstu_unit_chk chk (.clk(clk), .resetn(resetn), .instr_valid(instr_valid),
  .flag_in(flag_in), .busy_q(busy_q), .wb_en_q(wb_en_q), .flag_q(flag_q),
  .flag_wr_q(flag_wr_q), .mem_rd_q(mem_rd_q), .mem_wr_q(mem_wr_q), .mem_lock_q(mem_lock_q),
  .instr(instr), .dest_register(dest_register), .source_register(source_register),
  .wb_data_q(wb_data_q), .mem_addr_q(mem_addr_q), .dest_idx_q(dest_idx_q),
  .mem_rdata(mem_rdata), .mem_wdata_q(mem_wdata_q), .src_idx_q(src_idx_q),
  .illegal_q(illegal_q));
`default_nettype wire

// [bench/sstu_mem_model.sv]
// Byte memory standing on the far side of the test-and-set bus.
`timescale 1ns/1ps
`default_nettype none
module sstu_mem_model (
  input wire logic clk,
  input wire logic [31:0] mem_addr_q,
  input wire logic mem_rd_q, mem_wr_q, mem_lock_q,
  input wire logic [7:0] mem_wdata_q,
  output logic [7:0] mem_rdata
);
  logic [7:0] bytes [16];
  logic [3:0] a_q;
  logic rd_q = 1'b0;
  logic [7:0] pat_q = 8'h5a;
  // Outside a read and the cycle after it the data lines churn, so a later sample never sees a stale byte.
  always @(posedge clk) begin
    rd_q <= mem_rd_q;
    pat_q <= ~pat_q + 8'h03;
    if (mem_rd_q) a_q <= mem_addr_q[3:0];
    if (mem_wr_q && mem_lock_q) bytes[mem_addr_q[3:0]] <= mem_wdata_q;
  end
  assign mem_rdata = mem_rd_q ? bytes[mem_addr_q[3:0]] : rd_q ? bytes[a_q] : pat_q;
endmodule
`default_nettype wire

// [bench/test_subtract_swap_testset_unit.sv]
// Self-checking testbench for the subtract, swap and test-and-set unit.
`timescale 1ns/1ps
`default_nettype none
module test_subtract_swap_testset_unit;
  import sstu_pkg::*;
  logic clk = 0, resetn = 0, instr_valid = 0, flag_in = 0;
  logic [15:0] instr = 16'h0000;
  logic [31:0] dreg = 32'h0000_0000, sreg = 32'h0000_0000, wb_data_q, mem_addr_q, r1, r2;
  logic [7:0] mem_rdata, mem_wdata_q;
  logic [3:0] dest_idx_q;
  logic wb_en_q, flag_q, flag_wr_q, busy_q, mem_rd_q, mem_wr_q, mem_lock_q, illegal_q;
  logic [38:0] notes [$];
  logic [15:0] ops [5] = '{SSTU_OP_SUB, SSTU_OP_SUBB, SSTU_OP_CHECKED_SUBTRACT_OP, SSTU_OP_SWPB, SSTU_OP_SWPW};
  int miscompares = 0, n_checks = 0, seed = 2109;
  always #5 clk = ~clk;
  sstu_unit dut (.clk(clk), .resetn(resetn), .instr_valid(instr_valid), .instr(instr),
    .dest_register(dreg), .source_register(sreg), .flag_in(flag_in), .mem_rdata(mem_rdata),
    .dest_idx_q(dest_idx_q), .src_idx_q(), .wb_data_q(wb_data_q), .wb_en_q(wb_en_q),
    .flag_q(flag_q), .flag_wr_q(flag_wr_q), .busy_q(busy_q), .illegal_q(illegal_q),
    .mem_addr_q(mem_addr_q), .mem_rd_q(mem_rd_q), .mem_wr_q(mem_wr_q),
    .mem_lock_q(mem_lock_q), .mem_wdata_q(mem_wdata_q));
  sstu_mem_model mem (.clk(clk), .mem_addr_q(mem_addr_q), .mem_rd_q(mem_rd_q),
    .mem_wr_q(mem_wr_q), .mem_lock_q(mem_lock_q), .mem_wdata_q(mem_wdata_q),
    .mem_rdata(mem_rdata));
  task check(input logic [38:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task conclude;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task rr(input logic [15:0] op, input logic [31:0] d, s, input logic f);
    logic [32:0] b;
    logic [31:0] r;
    logic [7:0] ix;
    logic fw;
    logic fv;
    b = {1'b0, d} - {1'b0, s} - {32'h0000_0000, f};
    r = d - s;
    fw = 0;
    fv = 0;
    case (op)
      SSTU_OP_SUBB: begin r = b[31:0]; fw = 1; fv = b[32]; end
      SSTU_OP_CHECKED_SUBTRACT_OP: begin fw = 1; fv = (d[31] != s[31]) && (r[31] != d[31]); end
      SSTU_OP_SWPB: r = {s[31:16], s[7:0], s[15:8]};
      SSTU_OP_SWPW: r = {s[15:0], s[31:16]};
      default: ;
    endcase
    ix = 8'($random(seed));
    instr = op | {4'h0, ix, 4'h0};
    dreg = d;
    sreg = s;
    flag_in = f;
    instr_valid = 1;
    notes.push_back({1'b1, r, fw, fv, ix[7:4]});
    @(posedge clk) #1;
  endtask
  task tas(input logic [3:0] a, input logic [7:0] v);
    mem.bytes[a] = v;
    instr = SSTU_OP_TAS | 16'h0500;
    dreg = {28'h000_0000, a};
    instr_valid = 1;
    notes.push_back({1'b0, 32'h0000_0000, 1'b1, v == 8'h00, 4'h0});
    @(posedge clk) #1;
    instr_valid = 0;
    repeat (6) @(posedge clk);
    #1 check({31'h0, mem.bytes[a]}, {31'h0, v | 8'h80});
  endtask
  initial forever begin
    @(posedge clk) #1;
    if (wb_en_q === 1'b1 || flag_wr_q === 1'b1)
      check({wb_en_q, wb_en_q ? wb_data_q : 32'h0000_0000, flag_wr_q, flag_wr_q ? flag_q : 1'b0,
        wb_en_q ? dest_idx_q : 4'h0}, notes.size() ? notes.pop_front() : 39'h0);
  end
  initial begin
    #50000 miscompares++;
    conclude();
  end
  initial begin
    repeat (8) @(posedge clk);
    #1 resetn = 1;
    rr(SSTU_OP_SUB, 32'h8000_0000, 32'h0000_0001, 1'b1);
    rr(SSTU_OP_SUBB, 32'h0000_0000, 32'h0000_0001, 1'b0);
    rr(SSTU_OP_SUBB, 32'h0000_0000, 32'h0000_0000, 1'b1);
    rr(SSTU_OP_CHECKED_SUBTRACT_OP, 32'h8000_0001, 32'h0000_0002, 1'b0);
    rr(SSTU_OP_CHECKED_SUBTRACT_OP, 32'h7FFF_FFFE, 32'hFFFF_FFFE, 1'b0);
    rr(SSTU_OP_SWPB, 32'h0000_0000, 32'h1234_5678, 1'b0);
    rr(SSTU_OP_SWPW, 32'h0000_0000, 32'h1234_5678, 1'b0);
    for (int i = 0; i < 60; i++) begin
      r1 = $random(seed);
      r2 = $random(seed);
      rr(ops[r1[2:0] % 5], r2, $random(seed), r1[8]);
    end
    instr_valid = 0;
    @(posedge clk) #1;
    tas(4'h3, 8'h00);
    tas(4'h3, 8'h80);
    tas(4'h9, 8'($random(seed)));
    rr(SSTU_OP_CHECKED_SUBTRACT_OP, 32'h0000_0005, 32'h0000_0007, 1'b0);
    instr = 16'h3009;
    @(posedge clk) #1;
    check({38'h0, illegal_q}, 39'h1);
    instr_valid = 0;
    repeat (3) @(posedge clk);
    check(39'(notes.size()), 39'h0);
    conclude();
  end
endmodule
`default_nettype wire
